// ### lbm_bus_if.sv
// Interface: the multiplexed local bus pins between the master and its far end.
// Only the address/data lines and the open-drain lock pin are resolved here; undriven, those read high.
`timescale 1ns/1ps
interface lbm_bus_if (input logic ref_clk);
  logic [31:0] m_lad_o;
  logic m_lad_oe;
  logic [31:0] s_lad_o;
  logic s_lad_oe;
  logic [31:0] mux_addr_data_lines;
  logic addr_latch_n;
  logic addr_latch_oe;
  logic addr_state_ind_n;
  logic write_not_read;
  logic xfer_direction;
  logic data_window_n;
  logic [3:0] byte_lane_sel_n;
  logic cacheable;
  logic cacheable_oe;
  logic m_lock_oe;
  logic s_lock_oe;
  logic bus_lock_n;
  logic ready_n;
  logic access_error_n;
  logic bus_grant_ack;
  logic bus_grant_ack_oe;
  logic hold_or_grant_rcvd;
  logic agent_msg_or_irq0_n;
  logic bus_tick;

  localparam logic [31:0] LBM_LAD_IDLE_W = 32'hFFFFFFFF;

  // Wire resolution with pull-ups
  assign mux_addr_data_lines = m_lad_oe ? m_lad_o : (s_lad_oe ? s_lad_o : LBM_LAD_IDLE_W);
  assign bus_lock_n = ~(m_lock_oe | s_lock_oe);

  modport master (
    output m_lad_o, m_lad_oe, addr_latch_n, addr_latch_oe, addr_state_ind_n,
    output write_not_read, xfer_direction, data_window_n, byte_lane_sel_n,
    output cacheable, cacheable_oe, m_lock_oe, bus_grant_ack, bus_grant_ack_oe, bus_tick,
    input mux_addr_data_lines, bus_lock_n, ready_n, access_error_n,
    input hold_or_grant_rcvd, agent_msg_or_irq0_n
  );
  modport responder (
    output s_lad_o, s_lad_oe, s_lock_oe, ready_n, access_error_n,
    output hold_or_grant_rcvd, agent_msg_or_irq0_n,
    input mux_addr_data_lines, addr_latch_n, addr_latch_oe, addr_state_ind_n,
    input write_not_read, xfer_direction, data_window_n, byte_lane_sel_n,
    input cacheable, cacheable_oe, bus_lock_n, bus_grant_ack, bus_grant_ack_oe, bus_tick
  );
endinterface

// ### lbm_bus_props.sv
// Checker: timing relations of the local bus between master and responder.
// Assumes it sits beside the bus interface and sees its resolved signals.
`timescale 1ns/1ps
module lbm_bus_props (
  input wire logic ref_clk,
  input wire logic srst,
  input wire logic bus_tick,
  input wire logic m_lad_oe,
  input wire logic addr_latch_n,
  input wire logic addr_latch_oe,
  input wire logic addr_state_ind_n,
  input wire logic write_not_read,
  input wire logic xfer_direction,
  input wire logic data_window_n,
  input wire logic [3:0] byte_lane_sel_n,
  input wire logic cacheable_oe,
  input wire logic m_lock_oe,
  input wire logic ready_n,
  input wire logic bus_grant_ack,
  input wire logic bus_grant_ack_oe,
  input wire logic agent_msg_or_irq0_n
);
  logic prim_reg;
  logic prim_next;

  // Role strap counts only while reset is high
  always_comb
  begin
    prim_next = srst ? agent_msg_or_irq0_n : prim_reg;
  end

  always_ff @(posedge ref_clk)
  begin
    prim_reg <= prim_next;
  end

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (srst);

  // Address cycle is one bus cycle, then the data window opens
  sequence s_addr_cycle;
    !addr_latch_n [*2];
  endsequence
  sequence s_data_open;
    addr_latch_n && !data_window_n;
  endsequence

  property p_tick; bus_tick |=> !bus_tick; endproperty
  a_tick: assert property (p_tick) else $error("bus tick stuck high");
  property p_still;
    !bus_tick |=> $stable(addr_latch_n) && $stable(data_window_n) && $stable(addr_state_ind_n);
  endproperty
  a_still: assert property (p_still) else $error("strobe moved off tick");
  property p_aphase; $fell(addr_latch_n) |-> s_addr_cycle ##1 s_data_open; endproperty
  a_aphase: assert property (p_aphase) else $error("address cycle length");
  property p_addr;
    !addr_latch_n |-> m_lad_oe && addr_latch_oe && cacheable_oe && !addr_state_ind_n
      && byte_lane_sel_n inside {4'hE, 4'hD, 4'hB, 4'h7, 4'hC, 4'h3, 4'h0};
  endproperty
  a_addr: assert property (p_addr) else $error("address cycle drive");
  property p_idle; addr_latch_n && data_window_n |-> !m_lad_oe && !cacheable_oe; endproperty
  a_idle: assert property (p_idle) else $error("lines driven while idle");
  property p_dir;
    !data_window_n |-> xfer_direction == write_not_read && $stable(xfer_direction)
      && $stable(write_not_read);
  endproperty
  a_dir: assert property (p_dir) else $error("direction moved in window");
  property p_wait; bus_tick && !data_window_n && ready_n |=> addr_state_ind_n [*2]; endproperty
  a_wait: assert property (p_wait) else $error("address state in wait");
  property p_lanes; bus_tick && !data_window_n && ready_n |=> $stable(byte_lane_sel_n) [*2]; endproperty
  a_lanes: assert property (p_lanes) else $error("lanes moved in wait");
  property p_lock_on; $rose(m_lock_oe) |-> !addr_latch_n && !write_not_read; endproperty
  a_lock_on: assert property (p_lock_on) else $error("lock taken off read address");
  property p_lock_off; $fell(m_lock_oe) |-> !addr_latch_n && write_not_read; endproperty
  a_lock_off: assert property (p_lock_off) else $error("lock freed off write address");
  property p_hold;
    prim_reg && bus_grant_ack && bus_grant_ack_oe |-> !m_lad_oe && !addr_latch_oe && !cacheable_oe;
  endproperty
  a_hold: assert property (p_hold) else $error("lines driven in hold");
endmodule // lbm_bus_props

// ### lbm_fifo.sv
// Flip-flop FIFO with valid/ready on both sides.
// Full, empty and count are registered so ports come from flops.
`timescale 1ns/1ps
module lbm_fifo #(
  parameter int WIDTH = 32,
  parameter int DEPTH = 4
) (
  input wire logic ref_clk,
  input wire logic srst,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data,
  output logic [$clog2(DEPTH+1)-1:0] count
);
  localparam int PW = $clog2(DEPTH);
  localparam int CW = $clog2(DEPTH+1);
  logic [WIDTH-1:0] mem_reg [DEPTH];
  logic [PW-1:0] wr_reg, wr_next, rd_reg, rd_next;
  logic [CW-1:0] cnt_reg, cnt_next;
  logic full_reg, full_next, empty_reg, empty_next;
  logic push, pop;

  // Pointer and level update
  always_comb
  begin
    push = in_valid & ~full_reg;
    pop = out_ready & ~empty_reg;
    wr_next = push ? ((wr_reg == PW'(DEPTH-1)) ? '0 : wr_reg + 1'b1) : wr_reg;
    rd_next = pop ? ((rd_reg == PW'(DEPTH-1)) ? '0 : rd_reg + 1'b1) : rd_reg;
    cnt_next = cnt_reg + CW'(push) - CW'(pop);
    full_next = (cnt_next == CW'(DEPTH));
    empty_next = (cnt_next == '0);
  end

  always_ff @(posedge ref_clk)
  begin
    if (srst)
    begin
      wr_reg <= '0;
      rd_reg <= '0;
      cnt_reg <= '0;
      full_reg <= 1'b0;
      empty_reg <= 1'b1;
    end
    else
    begin
      wr_reg <= wr_next;
      rd_reg <= rd_next;
      cnt_reg <= cnt_next;
      full_reg <= full_next;
      empty_reg <= empty_next;
    end
    if (push)
      mem_reg[wr_reg] <= in_data;
  end

  assign in_ready = ~full_reg;
  assign out_valid = ~empty_reg;
  assign out_data = mem_reg[rd_reg];
  assign count = cnt_reg;
endmodule // lbm_fifo

// ### lbm_master.sv
// Bus master end: runs address, data and wait phases of the local bus.
// Assumes ref_clk is the double-rate clock; the far end samples on bus_tick.
// Overview of operation
// - Bus phases advance on ref_clk divided by two
// - Address phase: word address plus burst code
// - Burst code 00..11 means one to four words
// - Data on all lines, floated when inactive
// - Address latch low in address phase only
// - Address state low in address phase, bursts
// - Write indicator held through whole access
// - Direction fixed while data window active
// - Data window low through data and waits
// - Missing ready inserts a wait phase
// - Locked read waits for lock, then holds it
// - Locked write releases lock in address phase
// - Four lane selects, top lane bits 31:24
// - Lane selects lead data by one word
// - Lane selects held constant during waits
// - Only aligned, contiguous, nonempty lane groups
// - Primary grants hold, floats lines, acknowledges
// - Secondary reuses pins as request and grant
// - Cacheable marked in address phase, floats idle
// - Error after final ready flags that transaction
// - Strap in reset selects primary or secondary
`timescale 1ns/1ps
module lbm_master
  import lbm_pkg::*;
#(
  parameter int FIFO_DEPTH = LBM_FIFO_DEPTH
) (
  input wire logic ref_clk,
  input wire logic srst,
  input wire logic cmd_valid,
  output logic cmd_ack,
  input wire logic [29:0] cmd_addr,
  input wire logic [1:0] cmd_len,
  input wire logic cmd_write,
  input wire logic cmd_rmw,
  input wire logic cmd_cache,
  input wire logic [3:0] cmd_be,
  input wire logic wr_valid,
  output logic wr_ready,
  input wire logic [31:0] wr_data,
  output logic rd_valid,
  output logic [31:0] rd_data,
  output logic bus_error,
  output logic is_primary,
  lbm_bus_if.master bus
);
  localparam int CW = $clog2(FIFO_DEPTH+1);
  lbm_state_t state_reg, state_next;
  logic ph_reg, ph_next;
  logic role_reg, role_next;
  logic [1:0] cnt_reg, cnt_next;
  logic [31:0] lad_reg, lad_next;
  logic lad_oe_reg, lad_oe_next;
  logic ale_n_reg, ale_n_next, ale_oe_reg, ale_oe_next;
  logic ads_n_reg, ads_n_next;
  logic wnr_reg, wnr_next, dtr_reg, dtr_next;
  logic den_n_reg, den_n_next;
  logic [3:0] be_n_reg, be_n_next;
  logic cache_reg, cache_next, cache_oe_reg, cache_oe_next;
  logic lock_oe_reg, lock_oe_next;
  logic gnt_reg, gnt_next, gnt_oe_reg, gnt_oe_next;
  logic chk_reg, chk_next, err_reg, err_next;
  logic rdv_reg, rdv_next, ack_reg, ack_next;
  logic [31:0] rdd_reg, rdd_next;
  logic fifo_pop, fifo_valid;
  logic [31:0] fifo_data;
  logic [CW-1:0] fifo_count;
  logic can_start;

  // Write data path buffer; a write starts only once its whole burst sits here
  lbm_fifo #(.WIDTH(32), .DEPTH(FIFO_DEPTH)) u_wfifo (
    .ref_clk(ref_clk),
    .srst(srst),
    .in_valid(wr_valid),
    .in_ready(wr_ready),
    .in_data(wr_data),
    .out_valid(fifo_valid),
    .out_ready(fifo_pop),
    .out_data(fifo_data),
    .count(fifo_count)
  );

  // Start condition: data buffered for writes, foreign lock clear for locked reads
  always_comb
  begin
    can_start = (!cmd_write || (fifo_count > CW'(cmd_len))) &&
      !(cmd_rmw && !cmd_write && !bus.bus_lock_n && !lock_oe_reg);
  end

  // Sequencer next-state; state and strobes move only on the bus tick, user pulses last one ref_clk
  always_comb
  begin
    state_next = state_reg;
    ph_next = ~ph_reg;
    role_next = srst ? bus.agent_msg_or_irq0_n : role_reg;
    cnt_next = cnt_reg;
    lad_next = lad_reg;
    lad_oe_next = lad_oe_reg;
    ale_n_next = ale_n_reg;
    ale_oe_next = ale_oe_reg;
    ads_n_next = ads_n_reg;
    wnr_next = wnr_reg;
    dtr_next = dtr_reg;
    den_n_next = den_n_reg;
    be_n_next = be_n_reg;
    cache_next = cache_reg;
    cache_oe_next = cache_oe_reg;
    lock_oe_next = lock_oe_reg;
    gnt_next = gnt_reg;
    gnt_oe_next = 1'b1;
    chk_next = chk_reg;
    err_next = 1'b0;
    rdv_next = 1'b0;
    rdd_next = rdd_reg;
    ack_next = 1'b0;
    fifo_pop = 1'b0;
    if (ph_reg)
    begin
      unique case (state_reg)
        LBM_S_IDLE:
        begin
          // Error input belongs to the access that just ended
          if (chk_reg)
            err_next = ~bus.access_error_n;
          chk_next = 1'b0;
          if (role_reg && bus.hold_or_grant_rcvd)
          begin
            state_next = LBM_S_HOLD;
            gnt_next = 1'b1;
          end
          else if (!role_reg && !cmd_valid)
          begin
            state_next = LBM_S_HOLD;
            gnt_next = 1'b0;
          end
          else if (cmd_valid && can_start)
          begin
            state_next = LBM_S_ADDR;
            lad_next = {cmd_addr, cmd_len};
            lad_oe_next = 1'b1;
            ale_n_next = 1'b0;
            ale_oe_next = 1'b1;
            ads_n_next = 1'b0;
            wnr_next = cmd_write;
            dtr_next = cmd_write;
            // Illegal lane groups fall back to the whole word
            be_n_next = lbm_be_legal(cmd_be) ? ~cmd_be : ~LBM_BE_ALL;
            cache_next = cmd_cache;
            cache_oe_next = 1'b1;
            cnt_next = cmd_len;
            ack_next = 1'b1;
            if (cmd_rmw)
              lock_oe_next = ~cmd_write;
          end
        end
        LBM_S_ADDR:
        begin
          state_next = LBM_S_DATA;
          ale_n_next = 1'b1;
          ads_n_next = 1'b1;
          den_n_next = 1'b0;
          // Lanes shown now already describe the following word
          if (cnt_reg != LBM_LEN_1)
            be_n_next = ~LBM_BE_ALL;
          if (wnr_reg)
          begin
            lad_next = fifo_data;
            fifo_pop = 1'b1;
          end
          else
            lad_oe_next = 1'b0;
        end
        LBM_S_DATA:
        begin
          ads_n_next = 1'b1;
          if (!bus.ready_n)
          begin
            if (!wnr_reg)
            begin
              rdv_next = 1'b1;
              rdd_next = bus.mux_addr_data_lines;
            end
            if (cnt_reg == LBM_LEN_1)
            begin
              state_next = LBM_S_IDLE;
              den_n_next = 1'b1;
              lad_oe_next = 1'b0;
              ale_oe_next = 1'b0;
              cache_oe_next = 1'b0;
              chk_next = 1'b1;
            end
            else
            begin
              cnt_next = cnt_reg - 2'h1;
              ads_n_next = 1'b0;
              if (wnr_reg)
              begin
                lad_next = fifo_data;
                fifo_pop = 1'b1;
              end
            end
          end
          // Without ready the outputs, lanes included, hold; only the address state returns high
        end
        LBM_S_HOLD:
        begin
          if (role_reg)
          begin
            if (!bus.hold_or_grant_rcvd)
            begin
              state_next = LBM_S_IDLE;
              gnt_next = 1'b0;
            end
          end
          else
          begin
            gnt_next = cmd_valid;
            if (gnt_reg && cmd_valid && bus.hold_or_grant_rcvd)
              state_next = LBM_S_IDLE;
          end
        end
        default: state_next = LBM_S_HOLD;
      endcase
    end
  end

  // Registers; three-state pins float under reset
  always_ff @(posedge ref_clk)
  begin
    role_reg <= role_next;
    lad_reg <= lad_next;
    rdd_reg <= rdd_next;
    if (srst)
    begin
      state_reg <= LBM_S_HOLD;
      ph_reg <= 1'b0;
      cnt_reg <= LBM_LEN_1;
      lad_oe_reg <= 1'b0;
      ale_n_reg <= 1'b1;
      ale_oe_reg <= 1'b0;
      ads_n_reg <= 1'b1;
      wnr_reg <= 1'b0;
      dtr_reg <= 1'b0;
      den_n_reg <= 1'b1;
      be_n_reg <= ~LBM_BE_NONE;
      cache_reg <= 1'b0;
      cache_oe_reg <= 1'b0;
      lock_oe_reg <= 1'b0;
      gnt_reg <= 1'b0;
      gnt_oe_reg <= 1'b0;
      chk_reg <= 1'b0;
      err_reg <= 1'b0;
      rdv_reg <= 1'b0;
      ack_reg <= 1'b0;
    end
    else
    begin
      state_reg <= state_next;
      ph_reg <= ph_next;
      cnt_reg <= cnt_next;
      lad_oe_reg <= lad_oe_next;
      ale_n_reg <= ale_n_next;
      ale_oe_reg <= ale_oe_next;
      ads_n_reg <= ads_n_next;
      wnr_reg <= wnr_next;
      dtr_reg <= dtr_next;
      den_n_reg <= den_n_next;
      be_n_reg <= be_n_next;
      cache_reg <= cache_next;
      cache_oe_reg <= cache_oe_next;
      lock_oe_reg <= lock_oe_next;
      gnt_reg <= gnt_next;
      gnt_oe_reg <= gnt_oe_next;
      chk_reg <= chk_next;
      err_reg <= err_next;
      rdv_reg <= rdv_next;
      ack_reg <= ack_next;
    end
  end

  // Pin and user outputs straight from flops
  assign bus.m_lad_o = lad_reg;
  assign bus.m_lad_oe = lad_oe_reg;
  assign bus.addr_latch_n = ale_n_reg;
  assign bus.addr_latch_oe = ale_oe_reg;
  assign bus.addr_state_ind_n = ads_n_reg;
  assign bus.write_not_read = wnr_reg;
  assign bus.xfer_direction = dtr_reg;
  assign bus.data_window_n = den_n_reg;
  assign bus.byte_lane_sel_n = be_n_reg;
  assign bus.cacheable = cache_reg;
  assign bus.cacheable_oe = cache_oe_reg;
  assign bus.m_lock_oe = lock_oe_reg;
  assign bus.bus_grant_ack = gnt_reg;
  assign bus.bus_grant_ack_oe = gnt_oe_reg;
  assign bus.bus_tick = ph_reg;
  assign cmd_ack = ack_reg;
  assign rd_valid = rdv_reg;
  assign rd_data = rdd_reg;
  assign bus_error = err_reg;
  assign is_primary = role_reg;
endmodule // lbm_master

// ### lbm_pkg.sv
// Package: shared constants and types of the local burst bus master and its responder.
// Assumes both ends run on one ref_clk; the bus cycle is two ref_clk periods.
package lbm_pkg;
  localparam int LBM_DATA_W = 32;
  localparam int LBM_WADDR_W = 30;
  localparam int LBM_FIFO_DEPTH = 4;
  localparam int LBM_MEM_WORDS = 16;
  localparam int LBM_WAIT_STATES = 1;
  localparam logic [1:0] LBM_LEN_1 = 2'h0;
  localparam logic [1:0] LBM_LEN_4 = 2'h3;
  localparam logic [3:0] LBM_BE_ALL = 4'hF;
  localparam logic [3:0] LBM_BE_NONE = 4'h0;
  localparam logic [31:0] LBM_LAD_IDLE = 32'hFFFFFFFF;

  // Bus sequencer states; the wait phase is a data phase without ready
  typedef enum logic [3:0] {
    LBM_S_IDLE = 4'b0001,
    LBM_S_ADDR = 4'b0010,
    LBM_S_DATA = 4'b0100,
    LBM_S_HOLD = 4'b1000
  } lbm_state_t;

  // Lane mask is active high here; only aligned contiguous groups pass
  function automatic logic lbm_be_legal(input logic [3:0] be);
    unique case (be)
      4'h1, 4'h2, 4'h4, 4'h8, 4'h3, 4'hC, 4'hF: lbm_be_legal = 1'b1;
      default: lbm_be_legal = 1'b0;
    endcase
  endfunction
endpackage

// ### lbm_responder.sv
// Far end: small word memory with wait states, role strap and hold/grant arbiter.
// Assumes it shares ref_clk with the master; memory access steps only on bus_tick, hold/strap/lock every ref_clk.
`timescale 1ns/1ps
module lbm_responder
  import lbm_pkg::*;
#(
  parameter int MEM_WORDS = LBM_MEM_WORDS,
  parameter int WAIT_STATES = LBM_WAIT_STATES
) (
  input wire logic ref_clk,
  input wire logic srst,
  input wire logic primary_sel,
  input wire logic ext_hold_req,
  input wire logic ext_lock_req,
  output logic busy,
  lbm_bus_if.responder bus
);
  localparam int IW = $clog2(MEM_WORDS);
  logic [31:0] mem_reg [MEM_WORDS];
  logic [31:0] mem_next [MEM_WORDS];
  logic act_reg, act_next, wr_reg, wr_next, oob_reg, oob_next;
  logic [29:0] addr_reg, addr_next;
  logic [1:0] left_reg, left_next;
  logic [7:0] wcnt_reg, wcnt_next;
  logic rdy_n_reg, rdy_n_next, err_n_reg, err_n_next;
  logic [31:0] dout_reg, dout_next;
  logic dout_oe_reg, dout_oe_next;
  logic hold_reg, hold_next, strap_reg, strap_next, lock_reg, lock_next;
  logic [3:0] lane_n_reg, lane_n_next;

  function automatic logic word_oob(input logic [29:0] a);
    word_oob = (a >= 30'(MEM_WORDS));
  endfunction

  // Ready, read data and error sequencing on each bus tick
  always_comb
  begin
    mem_next = mem_reg;
    act_next = act_reg;
    wr_next = wr_reg;
    oob_next = oob_reg;
    addr_next = addr_reg;
    left_next = left_reg;
    wcnt_next = wcnt_reg;
    rdy_n_next = rdy_n_reg;
    err_n_next = err_n_reg;
    dout_next = dout_reg;
    dout_oe_next = dout_oe_reg;
    lane_n_next = lane_n_reg;
    strap_next = primary_sel;
    hold_next = primary_sel ? ext_hold_req : bus.bus_grant_ack;
    lock_next = ext_lock_req;
    if (bus.bus_tick)
    begin
      err_n_next = 1'b1;
      if (bus.addr_latch_oe && !bus.addr_latch_n)
      begin
        act_next = 1'b1;
        addr_next = bus.mux_addr_data_lines[31:2];
        left_next = bus.mux_addr_data_lines[1:0];
        wr_next = bus.write_not_read;
        oob_next = word_oob(bus.mux_addr_data_lines[31:2]);
        lane_n_next = bus.byte_lane_sel_n;
        wcnt_next = 8'(WAIT_STATES);
        rdy_n_next = (WAIT_STATES != 0);
        dout_next = mem_reg[bus.mux_addr_data_lines[IW+1:2]];
        dout_oe_next = !bus.write_not_read && (WAIT_STATES == 0);
      end
      else if (act_reg && !rdy_n_reg)
      begin
        if (wr_reg && !word_oob(addr_reg))
          for (int i = 0; i < 4; i++)
            if (!lane_n_reg[i])
              mem_next[addr_reg[IW-1:0]][8*i+:8] = bus.mux_addr_data_lines[8*i+:8];
        if (left_reg == LBM_LEN_1)
        begin
          // Error pulse lands in the cycle after the final ready
          act_next = 1'b0;
          rdy_n_next = 1'b1;
          dout_oe_next = 1'b0;
          err_n_next = ~oob_reg;
        end
        else
        begin
          addr_next = addr_reg + 30'h1;
          left_next = left_reg - 2'h1;
          oob_next = oob_reg | word_oob(addr_reg + 30'h1);
          lane_n_next = bus.byte_lane_sel_n;
          wcnt_next = 8'(WAIT_STATES);
          rdy_n_next = (WAIT_STATES != 0);
          dout_next = mem_reg[IW'(addr_reg + 30'h1)];
          dout_oe_next = !wr_reg && (WAIT_STATES == 0);
        end
      end
      else if (act_reg && (wcnt_reg != 8'h0))
      begin
        wcnt_next = wcnt_reg - 8'h1;
        rdy_n_next = (wcnt_reg != 8'h1);
        dout_oe_next = !wr_reg && (wcnt_reg == 8'h1);
      end
    end
  end

  always_ff @(posedge ref_clk)
  begin
    mem_reg <= mem_next;
    addr_reg <= addr_next;
    dout_reg <= dout_next;
    left_reg <= left_next;
    wcnt_reg <= wcnt_next;
    wr_reg <= wr_next;
    oob_reg <= oob_next;
    lane_n_reg <= lane_n_next;
    // Strap follows its select in reset too, when the master samples it
    strap_reg <= strap_next;
    if (srst)
    begin
      act_reg <= 1'b0;
      rdy_n_reg <= 1'b1;
      err_n_reg <= 1'b1;
      dout_oe_reg <= 1'b0;
      hold_reg <= 1'b0;
      lock_reg <= 1'b0;
    end
    else
    begin
      act_reg <= act_next;
      rdy_n_reg <= rdy_n_next;
      err_n_reg <= err_n_next;
      dout_oe_reg <= dout_oe_next;
      hold_reg <= hold_next;
      lock_reg <= lock_next;
    end
  end

  assign bus.s_lad_o = dout_reg;
  assign bus.s_lad_oe = dout_oe_reg;
  assign bus.s_lock_oe = lock_reg;
  assign bus.ready_n = rdy_n_reg;
  assign bus.access_error_n = err_n_reg;
  assign bus.hold_or_grant_rcvd = hold_reg;
  assign bus.agent_msg_or_irq0_n = strap_reg;
  assign busy = act_reg;
endmodule // lbm_responder

// ### testbench.sv
// Testbench: master and responder joined by the bus interface, self-checking.
// Assumes a 16-word responder memory; illegal lane masks become full words.
`timescale 1ns/1ps
module testbench import lbm_pkg::*;;
  logic ref_clk = 1'b0;
  logic srst, cmd_valid, cmd_write, cmd_rmw, cmd_cache, wr_valid, cmd_ack, wr_ready;
  logic primary_sel, ext_hold_req, ext_lock_req, rd_valid, bus_error, is_primary, busy;
  logic [29:0] cmd_addr;
  logic [1:0] cmd_len;
  logic [3:0] cmd_be;
  logic [31:0] wr_data, rd_data, d;
  logic [31:0] mem [LBM_MEM_WORDS];
  logic [31:0] exp_rd [$];
  logic exp_err [$];
  int fails = 0;
  int cmp_count = 0;
  int n, k;

  // Double-rate clock, 20 ns period
  always #10 ref_clk = ~ref_clk;

  lbm_bus_if i_lbm_bus_if (.ref_clk(ref_clk));
  lbm_master i_lbm_master (.ref_clk(ref_clk), .srst(srst), .cmd_valid(cmd_valid),
    .cmd_ack(cmd_ack), .cmd_addr(cmd_addr), .cmd_len(cmd_len), .cmd_write(cmd_write),
    .cmd_rmw(cmd_rmw), .cmd_cache(cmd_cache), .cmd_be(cmd_be), .wr_valid(wr_valid),
    .wr_ready(wr_ready), .wr_data(wr_data), .rd_valid(rd_valid), .rd_data(rd_data),
    .bus_error(bus_error), .is_primary(is_primary), .bus(i_lbm_bus_if));
  lbm_responder i_lbm_responder (.ref_clk(ref_clk), .srst(srst), .primary_sel(primary_sel),
    .ext_hold_req(ext_hold_req), .ext_lock_req(ext_lock_req), .busy(busy), .bus(i_lbm_bus_if));
  lbm_bus_props i_lbm_bus_props (.ref_clk(ref_clk), .srst(srst),
    .bus_tick(i_lbm_bus_if.bus_tick), .m_lad_oe(i_lbm_bus_if.m_lad_oe),
    .addr_latch_n(i_lbm_bus_if.addr_latch_n), .addr_latch_oe(i_lbm_bus_if.addr_latch_oe),
    .addr_state_ind_n(i_lbm_bus_if.addr_state_ind_n),
    .write_not_read(i_lbm_bus_if.write_not_read), .xfer_direction(i_lbm_bus_if.xfer_direction),
    .data_window_n(i_lbm_bus_if.data_window_n), .byte_lane_sel_n(i_lbm_bus_if.byte_lane_sel_n),
    .cacheable_oe(i_lbm_bus_if.cacheable_oe), .m_lock_oe(i_lbm_bus_if.m_lock_oe),
    .ready_n(i_lbm_bus_if.ready_n), .bus_grant_ack(i_lbm_bus_if.bus_grant_ack),
    .bus_grant_ack_oe(i_lbm_bus_if.bus_grant_ack_oe),
    .agent_msg_or_irq0_n(i_lbm_bus_if.agent_msg_or_irq0_n));

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      fails++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic report_and_stop();
    if (fails == 0 && cmp_count > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  // Bounded wait step; a hang ends the run as a failure
  task automatic tick(inout int c);
    @(negedge ref_clk);
    c++;
    if (c > 500)
    begin
      fails++;
      report_and_stop();
    end
  endtask

  task automatic push(input logic [31:0] w);
    int c;
    c = 0;
    @(negedge ref_clk);
    wr_valid = 1'b1;
    wr_data = w;
    while (wr_ready !== 1'b1)
      tick(c);
    @(negedge ref_clk);
    wr_valid = 1'b0;
  endtask

  // Command held until acknowledged; n counts the cycles it was refused
  task automatic issue(input int a, input int l, input logic w, input logic r, input logic [3:0] be);
    n = 0;
    @(negedge ref_clk);
    {cmd_addr, cmd_len, cmd_write, cmd_rmw, cmd_be} = {30'(a), 2'(l), w, r, be};
    cmd_cache = 1'($urandom);
    cmd_valid = 1'b1;
    while (cmd_ack !== 1'b1)
      tick(n);
    cmd_valid = 1'b0;
    check(i_lbm_bus_if.mux_addr_data_lines, {30'(a), 2'(l)});
    check(32'(i_lbm_bus_if.cacheable), 32'(cmd_cache));
  endtask

  task automatic wr_acc(input int a, input int l, input logic r, input logic [3:0] be);
    logic [3:0] m;
    m = (be inside {4'h1, 4'h2, 4'h4, 4'h8, 4'h3, 4'hC, 4'hF}) ? be : LBM_BE_ALL;
    for (int i = 0; i <= l; i++)
    begin
      d = $urandom;
      push(d);
      // Only the first word obeys the mask; later burst words are whole
      for (int b = 0; b < 4; b++)
        if (a + i < LBM_MEM_WORDS && (i > 0 || m[b]))
          mem[a + i][8*b+:8] = d[8*b+:8];
    end
    if (a >= LBM_MEM_WORDS)
      exp_err.push_back(1'b1);
    issue(a, l, 1'b1, r, be);
  endtask

  task automatic rd_acc(input int a, input int l, input logic r);
    for (int i = 0; i <= l; i++)
      exp_rd.push_back(mem[a + i]);
    issue(a, l, 1'b0, r, LBM_BE_ALL);
  endtask

  task automatic do_reset();
    srst = 1'b1;
    repeat (8) @(negedge ref_clk);
    srst = 1'b0;
  endtask

  // Read words and error pulses are matched against the oldest note
  always @(negedge ref_clk)
  begin
    if (rd_valid === 1'b1 && exp_rd.size() == 0)
      check(32'h0, 32'h1);
    else if (rd_valid === 1'b1)
      check(rd_data, exp_rd.pop_front());
    if (bus_error === 1'b1 && exp_err.size() == 0)
      check(32'h0, 32'h1);
    else if (bus_error === 1'b1)
      check(32'(bus_error), 32'(exp_err.pop_front()));
  end

  initial
  begin
    {srst, cmd_valid, wr_valid, ext_hold_req, ext_lock_req, primary_sel} = 6'h21;
    {cmd_addr, cmd_len, cmd_write, cmd_rmw, cmd_cache, cmd_be, wr_data} = '0;
    void'($urandom(32'h84DB));
    do_reset();
    check(32'(is_primary), 32'h1);
    // Fill the buffer until it refuses, then drain it as one burst
    for (int i = 0; i < 4; i++)
    begin
      d = $urandom;
      push(d);
      mem[i] = d;
    end
    check(32'(wr_ready), 32'h0);
    issue(0, 3, 1'b1, 1'b0, LBM_BE_ALL);
    rd_acc(0, 3, 1'b0);
    // Every burst code; illegal lane masks must fall back to a full word
    for (int l = 0; l < 4; l++)
    begin
      wr_acc(4 + l * (l + 1) / 2, l, 1'b0, l == 0 ? 4'h5 : (l == 1 ? 4'h0 : 4'h6));
      rd_acc(4 + l * (l + 1) / 2, l, 1'b0);
    end
    wr_acc(4, 1, 1'b0, 4'hC);
    rd_acc(4, 1, 1'b0);
    wr_acc(20, 0, 1'b0, LBM_BE_ALL);
    // Locked pair waits out a foreign lock
    ext_lock_req = 1'b1;
    fork
      begin
        repeat (30) @(negedge ref_clk);
        ext_lock_req = 1'b0;
      end
    join_none
    rd_acc(1, 0, 1'b1);
    check(32'(n >= 20), 32'h1);
    wr_acc(1, 0, 1'b1, LBM_BE_ALL);
    rd_acc(1, 0, 1'b0);
    // Hold request parks the primary master
    ext_hold_req = 1'b1;
    repeat (20) @(negedge ref_clk);
    check(32'(i_lbm_bus_if.bus_grant_ack), 32'h1);
    fork
      begin
        repeat (20) @(negedge ref_clk);
        ext_hold_req = 1'b0;
      end
    join_none
    rd_acc(2, 1, 1'b0);
    check(32'(n >= 15), 32'h1);
    k = 0;
    while (exp_rd.size() != 0 || exp_err.size() != 0)
      tick(k);
    check(32'(busy), 32'h0);
    // Secondary role: request and grant pins swap meaning
    primary_sel = 1'b0;
    do_reset();
    check(32'(is_primary), 32'h0);
    wr_acc(3, 0, 1'b0, LBM_BE_ALL);
    rd_acc(3, 0, 1'b0);
    k = 0;
    while (exp_rd.size() != 0)
      tick(k);
    repeat (10) @(negedge ref_clk);
    report_and_stop();
  end
endmodule // testbench
